// File: common/kcpc_pkg.sv
// Purpose: Shared constants and types for the keyed clock and power control unit.
// Assumes: 32-bit byte addresses and 32-bit data; registers are 8 bits wide in the low lane.
// Notes: Protected registers are written only through their three-write key sequence; wake-up returns the power mode field to normal.
package kcpc_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IRQ_N = 4;

  localparam logic [ADDR_W-1:0] OFF_POWER_KEY_FIRST = 32'hFFFF0404;
  localparam logic [ADDR_W-1:0] OFF_POWER_CONTROL = 32'hFFFF0408;
  localparam logic [ADDR_W-1:0] OFF_POWER_KEY_SECOND = 32'hFFFF040C;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_KEY_FIRST = 32'hFFFF0410;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_SOURCE_CONTROL = 32'hFFFF0414;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_KEY_SECOND = 32'hFFFF0418;

  localparam logic [REG_W-1:0] KEY_CLOCK_FIRST = 8'hAA;
  localparam logic [REG_W-1:0] KEY_CLOCK_SECOND = 8'h55;
  localparam logic [REG_W-1:0] KEY_POWER_FIRST = 8'h01;
  localparam logic [REG_W-1:0] KEY_POWER_SECOND = 8'hF4;

  localparam logic [REG_W-1:0] RST_CLOCK_SOURCE_CONTROL = 8'h21;
  localparam logic [REG_W-1:0] RST_POWER_CONTROL = 8'h03;
  localparam logic [REG_W-1:0] MASK_CLOCK_SOURCE_CONTROL = 8'h23;
  localparam logic [REG_W-1:0] MASK_POWER_CONTROL = 8'h77;

  localparam int REF_SEL_BIT = 5;
  localparam int MD_LSB = 0;
  localparam int MD_W = 2;
  localparam int PC_LSB = 4;
  localparam int PC_W = 3;
  localparam int CD_LSB = 0;
  localparam int CD_W = 3;

  localparam logic [MD_W-1:0] MD_PLL = 2'h1;
  localparam logic [MD_W-1:0] MD_EXT = 2'h3;

  localparam logic [PC_W-1:0] PC_NORMAL = 3'h0;
  localparam logic [PC_W-1:0] PC_PAUSE = 3'h1;
  localparam logic [PC_W-1:0] PC_NAP = 3'h2;
  localparam logic [PC_W-1:0] PC_SLEEP = 3'h3;
  localparam logic [PC_W-1:0] PC_STOP = 3'h4;

  typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED, KEY_STAGED} kcpc_key_e;
endpackage : kcpc_pkg

// File: core/kcpc_core.sv
// Purpose: Key-protected clock source and power mode control with wake-up handling.
// Assumes: Register port and timer wake are same-clock logic; interrupt lines and PLL lock come from other domains.
// Notes: Reference and clocking mode take effect on the timer wake from nap.
//
// Behaviour
// - Clock source update needs key AA, the register write, then key 55.
// - Power control update needs key 01, the register write, then key F4.
// - Reference bit five set picks internal oscillator; set at reset.
// - Reference bit cleared makes the PLL input come from the external crystal.
// - Clocking mode 01 is PLL by default, 11 external clock pin, others reserved.
// - Operating mode field codes normal, pause, nap, sleep, stop; others reserved.
// - In sleep, any external interrupt line or the second timer wakes the device.
// - Divider field sets core clock from full PLL rate, halving per step.
// - Core clock is PLL clock over two to the divider; reset divider three.
// - A programmed reference change is applied on the timer wake from nap.
// - PLL lock loss halts the core clock in PLL clocking mode, not with the external clock; interrupt raised once lock returns.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module kcpc_core (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [kcpc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [kcpc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [kcpc_pkg::IRQ_N-1:0] i_ext_irq,
  input wire logic i_timer_wake,
  input wire logic i_pll_lock,
  output logic [kcpc_pkg::DATA_W-1:0] o_rdata,
  output logic o_ref_internal,
  output logic [kcpc_pkg::MD_W-1:0] o_clk_mode,
  output logic o_ref_pending,
  output logic [kcpc_pkg::PC_W-1:0] o_op_mode,
  output logic [kcpc_pkg::CD_W-1:0] o_cpu_div,
  output logic o_core_run,
  output logic o_periph_run,
  output logic o_pll_run,
  output logic o_pll_irq
);
  import kcpc_pkg::*;

  typedef struct packed {
    kcpc_key_e cst;
    kcpc_key_e pst;
    logic [REG_W-1:0] clk_stage;
    logic [REG_W-1:0] pow_stage;
    logic [REG_W-1:0] clk_reg;
    logic [REG_W-1:0] pow_reg;
    logic ref_act;
    logic [MD_W-1:0] md_act;
    logic ref_pending;
    logic [IRQ_N-1:0] irq_s1;
    logic [IRQ_N-1:0] irq_s2;
    logic lock_s1;
    logic lock_s2;
    logic was_locked;
    logic lock_lost;
    logic pll_irq;
    logic core_run;
    logic periph_run;
    logic pll_run;
    logic [DATA_W-1:0] rdata;
  } kcpc_state_s;

  localparam kcpc_state_s RST_STATE = '{
    cst: KEY_IDLE,
    pst: KEY_IDLE,
    clk_stage: '0,
    pow_stage: '0,
    clk_reg: RST_CLOCK_SOURCE_CONTROL,
    pow_reg: RST_POWER_CONTROL,
    ref_act: RST_CLOCK_SOURCE_CONTROL[REF_SEL_BIT],
    md_act: RST_CLOCK_SOURCE_CONTROL[MD_LSB +: MD_W],
    ref_pending: 1'b0,
    irq_s1: '0,
    irq_s2: '0,
    lock_s1: 1'b0,
    lock_s2: 1'b0,
    was_locked: 1'b0,
    lock_lost: 1'b0,
    pll_irq: 1'b0,
    core_run: 1'b0,
    periph_run: 1'b1,
    pll_run: 1'b1,
    rdata: '0
  };

  kcpc_state_s r_reg;
  kcpc_state_s r_next;

  logic [REG_W-1:0] wbyte;
  logic [PC_W-1:0] mode_now;
  logic [PC_W-1:0] mode_nx;
  logic wake_irq;
  logic wake;
  logic clk_ok;
  logic pow_ok;

  assign wbyte = i_wdata[REG_W-1:0];
  assign mode_now = r_reg.pow_reg[PC_LSB +: PC_W];
  assign wake_irq = |r_reg.irq_s2;
  assign clk_ok = (r_reg.clk_stage[MD_LSB +: MD_W] == MD_PLL) ||
                  (r_reg.clk_stage[MD_LSB +: MD_W] == MD_EXT);
  assign pow_ok = r_reg.pow_stage[PC_LSB +: PC_W] <= PC_STOP;

  always_comb begin
    r_next = r_reg;
    wake = 1'b0;
    mode_nx = PC_NORMAL;
    r_next.irq_s1 = i_ext_irq;
    r_next.irq_s2 = r_reg.irq_s1;
    r_next.lock_s1 = i_pll_lock;
    r_next.lock_s2 = r_reg.lock_s1;
    r_next.pll_irq = 1'b0;
    // Wake-up from low-power modes returns the operating mode field to normal.
    case (mode_now)
      PC_PAUSE: wake = wake_irq || i_timer_wake;
      PC_NAP: wake = wake_irq || i_timer_wake;
      PC_SLEEP: wake = wake_irq || i_timer_wake;
      PC_STOP: wake = wake_irq;
      default: wake = 1'b0;
    endcase
    if (wake) begin
      r_next.pow_reg[PC_LSB +: PC_W] = PC_NORMAL;
    end
    if (mode_now == PC_NAP && i_timer_wake && r_reg.ref_pending) begin
      r_next.ref_act = r_reg.clk_reg[REF_SEL_BIT];
      r_next.md_act = r_reg.clk_reg[MD_LSB +: MD_W];
      r_next.ref_pending = 1'b0;
    end
    // Clock source key sequence; any other write breaks it.
    if (i_wr) begin
      r_next.cst = KEY_IDLE;
      case (r_reg.cst)
        KEY_ARMED: begin
          if (i_addr == OFF_CLOCK_SOURCE_CONTROL) begin
            r_next.clk_stage = wbyte & MASK_CLOCK_SOURCE_CONTROL;
            r_next.cst = KEY_STAGED;
          end
        end
        KEY_STAGED: begin
          if (i_addr == OFF_CLOCK_KEY_SECOND && wbyte == KEY_CLOCK_SECOND && clk_ok) begin
            r_next.clk_reg = r_reg.clk_stage;
            r_next.ref_pending = (r_reg.clk_stage[REF_SEL_BIT] != r_next.ref_act) ||
                                 (r_reg.clk_stage[MD_LSB +: MD_W] != r_next.md_act);
          end
        end
        default: r_next.cst = KEY_IDLE;
      endcase
      if (i_addr == OFF_CLOCK_KEY_FIRST && wbyte == KEY_CLOCK_FIRST) begin
        r_next.cst = KEY_ARMED;
      end
    end
    // Power control key sequence; the mode takes effect on commit.
    if (i_wr) begin
      r_next.pst = KEY_IDLE;
      case (r_reg.pst)
        KEY_ARMED: begin
          if (i_addr == OFF_POWER_CONTROL) begin
            r_next.pow_stage = wbyte & MASK_POWER_CONTROL;
            r_next.pst = KEY_STAGED;
          end
        end
        KEY_STAGED: begin
          if (i_addr == OFF_POWER_KEY_SECOND && wbyte == KEY_POWER_SECOND && pow_ok) begin
            r_next.pow_reg = r_reg.pow_stage;
          end
        end
        default: r_next.pst = KEY_IDLE;
      endcase
      if (i_addr == OFF_POWER_KEY_FIRST && wbyte == KEY_POWER_FIRST) begin
        r_next.pst = KEY_ARMED;
      end
    end
    // Lock loss halts the core in PLL clocking mode; loss while the PLL runs raises the interrupt on relock.
    if (r_reg.lock_s2) begin
      r_next.was_locked = 1'b1;
    end
    if (r_reg.was_locked && r_reg.pll_run && !r_reg.lock_s2) begin
      r_next.lock_lost = 1'b1;
    end
    if (r_reg.lock_lost && r_reg.lock_s2) begin
      r_next.lock_lost = 1'b0;
      r_next.pll_irq = 1'b1;
    end
    mode_nx = r_next.pow_reg[PC_LSB +: PC_W];
    r_next.core_run = (mode_nx == PC_NORMAL) &&
                      (r_next.md_act == MD_EXT || r_reg.lock_s2);
    r_next.periph_run = (mode_nx == PC_NORMAL) || (mode_nx == PC_PAUSE);
    r_next.pll_run = mode_nx <= PC_NAP;
    // Reads answer in the next cycle; key registers and unmapped addresses read zero.
    r_next.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        OFF_CLOCK_SOURCE_CONTROL: r_next.rdata = {{(DATA_W-REG_W){1'b0}}, r_reg.clk_reg};
        OFF_POWER_CONTROL: r_next.rdata = {{(DATA_W-REG_W){1'b0}}, r_reg.pow_reg};
        default: r_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg <= RST_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_rdata = r_reg.rdata;
  assign o_ref_internal = r_reg.ref_act;
  assign o_clk_mode = r_reg.md_act;
  assign o_ref_pending = r_reg.ref_pending;
  assign o_op_mode = r_reg.pow_reg[PC_LSB +: PC_W];
  assign o_cpu_div = r_reg.pow_reg[CD_LSB +: CD_W];
  assign o_core_run = r_reg.core_run;
  assign o_periph_run = r_reg.periph_run;
  assign o_pll_run = r_reg.pll_run;
  assign o_pll_irq = r_reg.pll_irq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence clk_key1_s;
    i_wr && i_addr == OFF_CLOCK_KEY_FIRST && i_wdata[REG_W-1:0] == KEY_CLOCK_FIRST;
  endsequence
  sequence clk_val_s;
    i_wr && i_addr == OFF_CLOCK_SOURCE_CONTROL &&
      (i_wdata[MD_W-1:0] == MD_PLL || i_wdata[MD_W-1:0] == MD_EXT);
  endsequence
  sequence clk_key2_s;
    i_wr && i_addr == OFF_CLOCK_KEY_SECOND && i_wdata[REG_W-1:0] == KEY_CLOCK_SECOND;
  endsequence
  sequence pow_key1_s;
    i_wr && i_addr == OFF_POWER_KEY_FIRST && i_wdata[REG_W-1:0] == KEY_POWER_FIRST;
  endsequence
  sequence pow_val_s;
    i_wr && i_addr == OFF_POWER_CONTROL && i_wdata[PC_LSB +: PC_W] <= PC_STOP;
  endsequence
  sequence pow_key2_s;
    i_wr && i_addr == OFF_POWER_KEY_SECOND && i_wdata[REG_W-1:0] == KEY_POWER_SECOND;
  endsequence

  clock_commit_a: assert property (
    clk_key1_s ##1 clk_val_s ##1 clk_key2_s |=>
      r_reg.clk_reg == ($past(i_wdata[REG_W-1:0], 2) & MASK_CLOCK_SOURCE_CONTROL))
    else $error("Clock source key sequence did not commit the value.");

  power_commit_a: assert property (
    pow_key1_s ##1 pow_val_s ##1 pow_key2_s ##1 !(wake && !i_wr) |->
      o_op_mode == $past(i_wdata[PC_LSB +: PC_W], 2) &&
      o_cpu_div == $past(i_wdata[CD_W-1:0], 2))
    else $error("Power control key sequence did not commit the value.");

  unkeyed_write_a: assert property (
    i_wr && i_addr == OFF_CLOCK_SOURCE_CONTROL && r_reg.cst == KEY_IDLE |=>
      ##1 $stable(r_reg.clk_reg))
    else $error("Clock source changed without the first key.");

  ref_apply_a: assert property (
    $changed(o_ref_internal) || $changed(o_clk_mode) |->
      $past(mode_now) == PC_NAP && $past(i_timer_wake))
    else $error("Reference changed outside a timer wake from nap.");

  sleep_wake_a: assert property (
    mode_now == PC_SLEEP && (wake_irq || i_timer_wake) && !i_wr |=> o_op_mode == PC_NORMAL)
    else $error("Sleep mode did not wake on a wake request.");

  lock_halt_a: assert property (
    !r_reg.lock_s2 && r_next.md_act == MD_PLL |=> !o_core_run)
    else $error("Core clock ran without PLL lock.");

  pll_irq_a: assert property (
    o_pll_irq |-> r_reg.lock_s2 && $past(r_reg.lock_lost) && !r_reg.lock_lost)
    else $error("PLL interrupt without a regained lock.");

  legal_codes_a: assert property (
    (o_clk_mode == MD_PLL || o_clk_mode == MD_EXT) && o_op_mode <= PC_STOP)
    else $error("Active mode holds a reserved code.");

  divider_read_a: assert property (
    i_rd && i_addr == OFF_POWER_CONTROL |=>
      o_rdata[CD_W-1:0] == $past(o_cpu_div) && o_rdata[DATA_W-1:REG_W] == '0)
    else $error("Divider readback differs from the active divider.");

  // Further checks on key handling, wake-up, relock, readback and run enables.
  sequence nap_timer_s;
    mode_now == PC_NAP && i_timer_wake && r_reg.ref_pending && !i_wr;
  endsequence
  sequence relock_s;
    r_reg.lock_lost && r_reg.lock_s2;
  endsequence
  sequence key_read_s;
    i_rd && (i_addr == OFF_CLOCK_KEY_FIRST || i_addr == OFF_CLOCK_KEY_SECOND ||
      i_addr == OFF_POWER_KEY_FIRST || i_addr == OFF_POWER_KEY_SECOND);
  endsequence

  power_unkeyed_a: assert property (
    i_wr && i_addr == OFF_POWER_CONTROL && r_reg.pst == KEY_IDLE |=> ##1 $stable(o_cpu_div))
    else $error("Power control changed without the first key.");

  nap_apply_a: assert property (
    nap_timer_s |=> !o_ref_pending &&
      o_ref_internal == $past(r_reg.clk_reg[REF_SEL_BIT]) &&
      o_clk_mode == $past(r_reg.clk_reg[MD_LSB +: MD_W]))
    else $error("Programmed reference was not applied on the timer wake from nap.");

  pending_set_a: assert property (
    clk_key1_s ##1 clk_val_s ##1 clk_key2_s |=>
      o_ref_pending == (r_reg.clk_reg[REF_SEL_BIT] != o_ref_internal ||
        r_reg.clk_reg[MD_LSB +: MD_W] != o_clk_mode))
    else $error("Pending flag does not reflect the committed clock source.");

  reserved_drop_a: assert property (
    pow_key1_s ##1 i_wr && i_addr == OFF_POWER_CONTROL && i_wdata[PC_LSB +: PC_W] > PC_STOP
      ##1 pow_key2_s |=> $stable(o_cpu_div))
    else $error("A reserved operating mode was committed.");

  stop_hold_a: assert property (
    mode_now == PC_STOP && !wake_irq && !i_wr |=> o_op_mode == PC_STOP)
    else $error("Stop mode left without an external interrupt.");

  pause_wake_a: assert property (
    mode_now == PC_PAUSE && (wake_irq || i_timer_wake) && !i_wr |=> o_op_mode == PC_NORMAL)
    else $error("Pause mode did not wake on a wake request.");

  pll_irq_pulse_a: assert property (
    relock_s |=> o_pll_irq ##1 !o_pll_irq)
    else $error("PLL interrupt was not a single pulse on relock.");

  key_read_a: assert property (
    key_read_s |=> o_rdata == '0)
    else $error("A key register read returned data.");

  clock_read_a: assert property (
    i_rd && i_addr == OFF_CLOCK_SOURCE_CONTROL |=>
      o_rdata == {{(DATA_W-REG_W){1'b0}}, $past(r_reg.clk_reg)})
    else $error("Clock source readback differs from the register.");

  run_enables_a: assert property (
    o_periph_run == (o_op_mode == PC_NORMAL || o_op_mode == PC_PAUSE) &&
      o_pll_run == (o_op_mode <= PC_NAP))
    else $error("Run enables disagree with the operating mode.");

  core_mode_a: assert property (
    o_op_mode != PC_NORMAL |-> !o_core_run)
    else $error("Core clock ran outside normal mode.");
endmodule : kcpc_core

// File: verification/test_kcpc_core.sv
// Purpose: Self-checking bench for the keyed clock and power control unit.
// Assumes: All inputs change by non-blocking assignment at the rising edge.
// Notes: The design holds its own assertions; this bench compares port values.
`timescale 1ns/1ps
module test_kcpc_core;
  import kcpc_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, i_timer_wake, i_pll_lock;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [IRQ_N-1:0] i_ext_irq;
  logic o_ref_internal, o_ref_pending, o_core_run, o_periph_run, o_pll_run, o_pll_irq;
  logic [MD_W-1:0] o_clk_mode;
  logic [PC_W-1:0] o_op_mode;
  logic [CD_W-1:0] o_cpu_div;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [10:0] rows [6];
  localparam logic [31:0] PKF = OFF_POWER_KEY_FIRST;
  localparam logic [31:0] PCR = OFF_POWER_CONTROL;
  localparam logic [31:0] PKS = OFF_POWER_KEY_SECOND;
  localparam logic [31:0] CKF = OFF_CLOCK_KEY_FIRST;
  localparam logic [31:0] CSR = OFF_CLOCK_SOURCE_CONTROL;
  localparam logic [31:0] CKS = OFF_CLOCK_KEY_SECOND;

  kcpc_core kcpc_core_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_irq(i_ext_irq),
    .i_timer_wake(i_timer_wake), .i_pll_lock(i_pll_lock), .o_rdata(o_rdata),
    .o_ref_internal(o_ref_internal), .o_clk_mode(o_clk_mode), .o_ref_pending(o_ref_pending),
    .o_op_mode(o_op_mode), .o_cpu_div(o_cpu_div), .o_core_run(o_core_run),
    .o_periph_run(o_periph_run), .o_pll_run(o_pll_run), .o_pll_irq(o_pll_irq));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic r, input logic [31:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= {24'h0, d};
  endtask : bus

  task automatic idle(input int n);
    repeat (n) bus(1'h0, 1'h0, 32'h0, 8'h0);
    #1;
  endtask : idle

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    bus(1'h0, 1'h1, a, 8'h0);
    idle(1);
    chk("rdata", o_rdata, {24'h0, e});
  endtask : rd

  task automatic seq(input logic [31:0] a1, input logic [7:0] k1, input logic [31:0] ar,
      input logic [7:0] v, input logic [31:0] a2, input logic [7:0] k2);
    bus(1'h1, 1'h0, a1, k1);
    bus(1'h1, 1'h0, ar, v);
    bus(1'h1, 1'h0, a2, k2);
    idle(2);
  endtask : seq

  task automatic pw(input logic [7:0] v);
    seq(PKF, 8'h01, PCR, v, PKS, 8'hF4);
  endtask : pw

  task automatic cw(input logic [7:0] v);
    seq(CKF, 8'hAA, CSR, v, CKS, 8'h55);
  endtask : cw

  task automatic waitm(input logic [2:0] e);
    for (int n = 0; n < 10 && o_op_mode !== e; n++) idle(1);
    chk("op_mode", o_op_mode, e);
  endtask : waitm

  task automatic tpulse();
    @(posedge i_clk);
    i_timer_wake <= 1'h1;
    @(posedge i_clk);
    i_timer_wake <= 1'h0;
    #1;
  endtask : tpulse

  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    {i_rst_n, i_wr, i_rd, i_timer_wake, i_pll_lock} = 5'h1;
    i_addr = 32'h0;
    i_wdata = 32'h0;
    i_ext_irq = 4'h0;
    rows = '{{8'h00, 3'h7}, {8'h17, 3'h3}, {8'h25, 3'h1}, {8'h31, 3'h0}, {8'h42, 3'h0},
      {8'h03, 3'h7}};
    repeat (12) @(posedge i_clk);
    #1;
    chk("reset", {o_ref_internal, o_clk_mode, o_op_mode, o_cpu_div}, 9'h143);
    chk("reset_run", {o_periph_run, o_pll_run, o_pll_irq}, 3'h6);
    @(posedge i_clk);
    i_rst_n <= 1'h1;
    idle(4);
    chk("core_run", o_core_run, 1'h1);
    rd(CSR, 8'h21);
    rd(PCR, 8'h03);
    rd(PKF, 8'h00);
    rd(32'hFFFF0400, 8'h00);
    foreach (rows[i]) begin
      pw(rows[i][10:3]);
      chk("op_mode", o_op_mode, rows[i][9:7]);
      chk("cpu_div", o_cpu_div, rows[i][5:3]);
      chk("run", {o_core_run, o_periph_run, o_pll_run}, rows[i][2:0]);
      rd(PCR, rows[i][10:3]);
    end
    seq(PKF, 8'h02, PCR, 8'h10, PKS, 8'hF4);
    rd(PCR, 8'h03);
    bus(1'h1, 1'h0, PKF, 8'h01);
    bus(1'h1, 1'h0, 32'hFFFF0400, 8'h00);
    seq(PCR, 8'h10, PKS, 8'hF4, PKS, 8'hF4);
    rd(PCR, 8'h03);
    seq(PKF, 8'h01, PCR, 8'h10, PKS, 8'h55);
    rd(PCR, 8'h03);
    pw(8'h57);
    rd(PCR, 8'h03);
    seq(CKF, 8'hAA, CSR, 8'h01, CKS, 8'hF4);
    rd(CSR, 8'h21);
    seq(CKF, 8'hAB, CSR, 8'h01, CKS, 8'h55);
    rd(CSR, 8'h21);
    cw(8'h20);
    rd(CSR, 8'h21);
    @(posedge i_clk);
    i_pll_lock <= 1'h0;
    for (int n = 0; n < 8 && o_core_run !== 1'h0; n++) idle(1);
    chk("core_run", o_core_run, 1'h0);
    chk("pll_irq", o_pll_irq, 1'h0);
    @(posedge i_clk);
    i_pll_lock <= 1'h1;
    for (int n = 0; n < 8 && o_pll_irq !== 1'h1; n++) idle(1);
    chk("pll_irq", o_pll_irq, 1'h1);
    idle(1);
    chk("pll_irq", o_pll_irq, 1'h0);
    cw(8'h01);
    rd(CSR, 8'h01);
    chk("pending", {o_ref_pending, o_ref_internal}, 2'h3);
    pw(8'h23);
    tpulse();
    waitm(PC_NORMAL);
    chk("active", {o_ref_pending, o_ref_internal, o_clk_mode}, 4'h1);
    cw(8'h03);
    pw(8'h23);
    tpulse();
    waitm(PC_NORMAL);
    chk("clk_mode", o_clk_mode, MD_EXT);
    @(posedge i_clk);
    i_pll_lock <= 1'h0;
    idle(6);
    chk("core_run", o_core_run, 1'h1);
    @(posedge i_clk);
    i_pll_lock <= 1'h1;
    for (int j = 0; j < 5; j++) begin
      pw(8'h33);
      chk("op_mode", o_op_mode, PC_SLEEP);
      if (j < 4) begin
        @(posedge i_clk);
        i_ext_irq <= 4'h1 << j;
        waitm(PC_NORMAL);
        @(posedge i_clk);
        i_ext_irq <= 4'h0;
      end else begin
        tpulse();
        waitm(PC_NORMAL);
      end
      idle(4);
    end
    pw(8'h43);
    tpulse();
    idle(3);
    chk("op_mode", o_op_mode, PC_STOP);
    @(posedge i_clk);
    i_ext_irq <= 4'h4;
    waitm(PC_NORMAL);
    @(posedge i_clk);
    i_ext_irq <= 4'h0;
    idle(4);
    pw(8'h16);
    chk("op_mode", o_op_mode, PC_PAUSE);
    @(posedge i_clk);
    i_ext_irq <= 4'h2;
    waitm(PC_NORMAL);
    chk("cpu_div", o_cpu_div, 3'h6);
    @(posedge i_clk);
    i_rst_n <= 1'h0;
    i_ext_irq <= 4'h0;
    idle(2);
    chk("reset", {o_ref_internal, o_clk_mode, o_op_mode, o_cpu_div}, 9'h143);
    chk("reset_run", {o_core_run, o_periph_run, o_pll_run, o_pll_irq, o_ref_pending}, 5'h0C);
    chk("rdata", o_rdata, 32'h0);
    @(posedge i_clk);
    i_rst_n <= 1'h1;
    idle(2);
    chk("core_run", o_core_run, 1'h0);
    idle(1);
    chk("core_run", o_core_run, 1'h1);
    rd(CSR, 8'h21);
    stop_test();
  end
endmodule : test_kcpc_core
